//--- hw/irxm_chan_filter.sv
// Per-packet channel filter against the upper channel mask
`timescale 1ns/1ps
`default_nettype none
module irxm_chan_filter
  import irxm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Mask and link gate
  input wire logic [IRXM_MASK_W-1:0] mask,
  input wire logic link_on,
  // Packet in, verdict out
  input wire irxm_pkt_t pkt,
  output irxm_verdict_t verdict
);

  irxm_verdict_t verdict_r;
  irxm_verdict_t verdict_nxt;
  logic upper;

  // Only channels from the base upward belong to this mask
  assign upper = (pkt.chan >= IRXM_CHAN_BASE);
  assign verdict = verdict_r;

  always_comb
  begin
    verdict_nxt.done = pkt.valid;
    verdict_nxt.upper = pkt.valid && upper;
    // Disabled link drops everything regardless of the mask
    verdict_nxt.accept = pkt.valid && upper && link_on
      && mask[5'(pkt.chan - IRXM_CHAN_BASE)];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      verdict_r <= '0;
    end
    else
    begin
      verdict_r <= verdict_nxt;
    end
  end

endmodule
`default_nettype wire

//--- hw/irxm_pkg.sv
// Shared constants and types for the upper isochronous receive channel mask
package irxm_pkg;

  // Register map, byte addresses
  localparam logic [7:0] IRXM_OFS_MASK_SET = 8'h70;
  localparam logic [7:0] IRXM_OFS_MASK_CLR = 8'h74;

  // Mask reset value; the stored mask has no documented reset state
  localparam logic [31:0] IRXM_MASK_RST = 32'h0000_0000;

  // Mask geometry: bit k selects channel k plus the base
  localparam int unsigned IRXM_MASK_W = 32;
  localparam int unsigned IRXM_CHAN_W = 6;
  localparam logic [5:0] IRXM_CHAN_BASE = 6'h20;

  // AXI4-Lite response codes
  localparam logic [1:0] IRXM_RESP_OKAY = 2'h0;
  localparam logic [1:0] IRXM_RESP_SLVERR = 2'h2;

  // Write and read channel states
  typedef enum logic {IRXM_WS_COLLECT, IRXM_WS_RESP} irxm_wst_t;
  typedef enum logic {IRXM_RS_IDLE, IRXM_RS_DATA} irxm_rst_t;

  // Held write data beat
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } irxm_wbeat_t;

  // Incoming packet header as seen by the filter
  typedef struct packed {
    logic valid;
    logic [5:0] chan;
  } irxm_pkt_t;

  // Filter verdict
  typedef struct packed {
    logic done;
    logic accept;
    logic upper;
  } irxm_verdict_t;

endpackage

//--- hw/irxm_slot.sv
// One-entry holding slot for an AXI4-Lite address or data beat
`timescale 1ns/1ps
`default_nettype none
module irxm_slot
  import irxm_pkg::*;
#(
  parameter int unsigned W = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Source side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Holding side
  input wire logic block,
  input wire logic take,
  output logic held_valid,
  output logic [W-1:0] held_data
);

  logic valid_r;
  logic valid_nxt;
  logic [W-1:0] data_r;
  logic [W-1:0] data_nxt;

  // One beat at a time; stays closed while the write is answered
  assign in_ready = !valid_r && !block;
  assign held_valid = valid_r;
  assign held_data = data_r;

  always_comb
  begin
    valid_nxt = valid_r;
    data_nxt = data_r;
    if (take)
    begin
      valid_nxt = 1'b0;
    end
    else if (in_valid && in_ready)
    begin
      valid_nxt = 1'b1;
      data_nxt = in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_r <= 1'b0;
      data_r <= '0;
    end
    else
    begin
      valid_r <= valid_nxt;
      data_r <= data_nxt;
    end
  end

endmodule
`default_nettype wire

//--- hw/irxm_top.sv
// Upper isochronous receive channel mask with AXI4-Lite set/clear access
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Hold one mask bit for each of the upper 32 isochronous channels.
// - Mask reachable at set address 70h and clear address 74h, one store.
// - Read at either address returns the stored mask, no side effect.
// - Mask bit k governs channel k plus 32; bit 31 is channel 63.
// - A one in a channel's bit lets packets on that channel be accepted.
// - With the link gate low, no packet is accepted at all.
module irxm_top
  import irxm_pkg::*;
#(
  parameter int unsigned AW = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Link gate from the host control logic, same clock
  input wire logic link_active_gate,
  // Received packet header
  input wire irxm_pkt_t pkt_in,
  // Filter verdict, one cycle after the header
  output irxm_verdict_t pkt_verdict,
  // Mask as seen by the receive logic
  output logic [IRXM_MASK_W-1:0] chan_mask,
  output logic upper_chan_top_enable,
  output logic upper_chan_bottom_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [IRXM_MASK_W-1:0] mask_r;
  logic [IRXM_MASK_W-1:0] mask_nxt;
  irxm_wst_t wst_r;
  irxm_wst_t wst_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  irxm_rst_t rst_r;
  irxm_rst_t rst_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;

  logic aw_held;
  logic [AW-1:0] aw_addr;
  logic w_held;
  irxm_wbeat_t w_beat;
  irxm_wbeat_t w_in;
  logic wr_go;
  logic wr_block;
  logic set_hit;
  logic clr_hit;
  logic rd_take;
  logic rd_hit;
  logic [31:0] strb_bits;
  logic sel_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Address and data holding slots

  assign w_in = '{data: s_axi_wdata, strb: s_axi_wstrb};
  assign wr_block = (wst_r != IRXM_WS_COLLECT);

  irxm_slot #(.W(AW)) u_aw_slot (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(s_axi_awvalid),
    .in_data(s_axi_awaddr),
    .in_ready(s_axi_awready),
    .block(wr_block),
    .take(wr_go),
    .held_valid(aw_held),
    .held_data(aw_addr)
  );

  irxm_slot #(.W($bits(irxm_wbeat_t))) u_w_slot (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(s_axi_wvalid),
    .in_data(w_in),
    .in_ready(s_axi_wready),
    .block(wr_block),
    .take(wr_go),
    .held_valid(w_held),
    .held_data(w_beat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode and mask update

  // Both addresses land on the same stored mask
  assign set_hit = (aw_addr[AW-1:2] == IRXM_OFS_MASK_SET[AW-1:2]);
  assign clr_hit = (aw_addr[AW-1:2] == IRXM_OFS_MASK_CLR[AW-1:2]);
  assign wr_go = aw_held && w_held && (wst_r == IRXM_WS_COLLECT);

  // Byte strobes widen into a bit mask; unstrobed lanes are left alone
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      strb_bits[b*8 +: 8] = {8{w_beat.strb[b]}};
    end
  end

  always_comb
  begin
    mask_nxt = mask_r;
    wst_nxt = wst_r;
    bresp_nxt = bresp_r;
    unique case (wst_r)
      IRXM_WS_COLLECT:
      begin
        if (wr_go)
        begin
          wst_nxt = IRXM_WS_RESP;
          bresp_nxt = IRXM_RESP_OKAY;
          if (set_hit)
          begin
            mask_nxt = mask_r | (w_beat.data & strb_bits);
          end
          else if (clr_hit)
          begin
            mask_nxt = mask_r & ~(w_beat.data & strb_bits);
          end
          else
          begin
            bresp_nxt = IRXM_RESP_SLVERR;
          end
        end
      end
      IRXM_WS_RESP:
      begin
        if (s_axi_bready)
        begin
          wst_nxt = IRXM_WS_COLLECT;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_r <= IRXM_MASK_RST;
      wst_r <= IRXM_WS_COLLECT;
      bresp_r <= IRXM_RESP_OKAY;
    end
    else
    begin
      mask_r <= mask_nxt;
      wst_r <= wst_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  assign s_axi_bvalid = (wst_r == IRXM_WS_RESP);
  assign s_axi_bresp = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  assign s_axi_arready = (rst_r == IRXM_RS_IDLE);
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_hit = (s_axi_araddr[AW-1:2] == IRXM_OFS_MASK_SET[AW-1:2])
    || (s_axi_araddr[AW-1:2] == IRXM_OFS_MASK_CLR[AW-1:2]);

  always_comb
  begin
    rst_nxt = rst_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    unique case (rst_r)
      IRXM_RS_IDLE:
      begin
        if (rd_take)
        begin
          rst_nxt = IRXM_RS_DATA;
          // Reading never touches the mask itself
          rdata_nxt = rd_hit ? mask_r : 32'h0000_0000;
          rresp_nxt = rd_hit ? IRXM_RESP_OKAY : IRXM_RESP_SLVERR;
        end
      end
      IRXM_RS_DATA:
      begin
        if (s_axi_rready)
        begin
          rst_nxt = IRXM_RS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_r <= IRXM_RS_IDLE;
      rdata_r <= 32'h0000_0000;
      rresp_r <= IRXM_RESP_OKAY;
    end
    else
    begin
      rst_r <= rst_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_rvalid = (rst_r == IRXM_RS_DATA);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Receive side

  assign chan_mask = mask_r;
  assign upper_chan_top_enable = mask_r[31];
  assign upper_chan_bottom_enable = mask_r[0];

  irxm_chan_filter u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .mask(mask_r),
    .link_on(link_active_gate),
    .pkt(pkt_in),
    .verdict(pkt_verdict)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  assign sel_bit = mask_r[pkt_in.chan[4:0]];

  a_set_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_go && set_hit && (w_beat.strb == 4'hf)
    |=> mask_r == ($past(mask_r) | $past(w_beat.data)))
    else $error("set write did not OR data into mask");

  a_clr_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_go && clr_hit && (w_beat.strb == 4'hf)
    |=> mask_r == ($past(mask_r) & ~$past(w_beat.data)))
    else $error("clear write did not remove bits from mask");

  a_two_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_go && !set_hit && !clr_hit |=> $stable(mask_r) && s_axi_bvalid
      && (s_axi_bresp == IRXM_RESP_SLVERR))
    else $error("unmapped write changed mask or was not refused");

  a_read_value: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_take && rd_hit |=> s_axi_rvalid && (s_axi_rdata == $past(mask_r))
      && (s_axi_rresp == IRXM_RESP_OKAY))
    else $error("read did not return stored mask");

  a_mask_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    !wr_go |=> $stable(mask_r))
    else $error("mask changed without a write");

  a_top_channel: assert property (
    @(posedge clk) disable iff (!rst_n)
    pkt_in.valid && (pkt_in.chan == 6'h3f) && link_active_gate
    |=> pkt_verdict.done && (pkt_verdict.accept == $past(mask_r[31])))
    else $error("channel 63 not governed by mask bit 31");

  a_accept_hit: assert property (
    @(posedge clk) disable iff (!rst_n)
    pkt_in.valid && pkt_in.chan[5] && link_active_gate
    |=> pkt_verdict.upper && (pkt_verdict.accept == $past(sel_bit)))
    else $error("upper channel verdict disagrees with mask bit");

  a_lower_reject: assert property (
    @(posedge clk) disable iff (!rst_n)
    pkt_in.valid && !pkt_in.chan[5] |=> !pkt_verdict.accept && !pkt_verdict.upper)
    else $error("lower channel accepted by upper mask");

  a_link_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    !link_active_gate |=> !pkt_verdict.accept)
    else $error("packet accepted while link gate low");

  a_bresp_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");

endmodule
`default_nettype wire

//--- sim/irxm_tb_top.sv
// Self-checking bench for the upper receive channel mask block
`timescale 1ns/1ps
`default_nettype none
module irxm_tb_top;
  import irxm_pkg::*;

  logic clk;
  logic rst_n;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, chan_mask;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic gate, top_en, bot_en;
  irxm_pkt_t pkt;
  irxm_verdict_t verdict;
  int failures = 0;
  int cmp_count = 0;

  irxm_top #(.AW(8)) u_dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .link_active_gate(gate), .pkt_in(pkt), .pkt_verdict(verdict),
    .chan_mask(chan_mask), .upper_chan_top_enable(top_en),
    .upper_chan_bottom_enable(bot_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Readies are combinational, so handshakes are judged at the settled negedge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic ah, wh, bh;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh)
    begin
      @(negedge clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid & bready;
      if (bh)
        check("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge clk);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
      if (bh)
        bready <= 1'b0;
    end
    // Response gone, both slots open again
    @(negedge clk);
    check("write reopen", {29'h0, bvalid, awready, wready}, 32'h3);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, rh;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    rh = 1'b0;
    while (!rh)
    begin
      @(negedge clk);
      ah = arvalid & arready;
      rh = rvalid & rready;
      if (rh)
      begin
        check("rdata", rdata, ed);
        check("rresp", {30'h0, rresp}, {30'h0, er});
      end
      @(posedge clk);
      if (ah)
        arvalid <= 1'b0;
      if (rh)
        rready <= 1'b0;
    end
    // Read data gone, address channel open again
    @(negedge clk);
    check("read reopen", {30'h0, rvalid, arready}, 32'h1);
  endtask

  // Verdict bits are done, accept, upper from high to low
  task automatic send_pkt(input logic [5:0] ch, input logic g, input logic [2:0] ev);
    @(posedge clk);
    pkt <= '{valid: 1'b1, chan: ch};
    gate <= g;
    @(posedge clk);
    pkt <= '0;
    @(negedge clk);
    check("verdict", {29'h0, verdict}, {29'h0, ev});
    @(negedge clk);
    check("verdict gone", {29'h0, verdict}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(negedge clk);
    check("mask at reset", chan_mask, IRXM_MASK_RST);
    check("idle bvalid", {31'h0, bvalid}, 32'h0);
    check("idle awready", {31'h0, awready}, 32'h1);
  endtask

  task automatic t_set_clear();
    axi_wr(IRXM_OFS_MASK_SET, 32'h8000_0001, 4'hf, IRXM_RESP_OKAY);
    check("mask after set", chan_mask, 32'h8000_0001);
    check("top enable", {31'h0, top_en}, 32'h1);
    check("bottom enable", {31'h0, bot_en}, 32'h1);
    axi_rd(IRXM_OFS_MASK_SET, 32'h8000_0001, IRXM_RESP_OKAY);
    axi_rd(IRXM_OFS_MASK_CLR, 32'h8000_0001, IRXM_RESP_OKAY);
    axi_wr(IRXM_OFS_MASK_CLR, 32'h0000_0001, 4'hf, IRXM_RESP_OKAY);
    check("mask after clear", chan_mask, 32'h8000_0000);
    check("bottom cleared", {31'h0, bot_en}, 32'h0);
    axi_rd(IRXM_OFS_MASK_CLR, 32'h8000_0000, IRXM_RESP_OKAY);
    axi_rd(IRXM_OFS_MASK_SET, 32'h8000_0000, IRXM_RESP_OKAY);
  endtask

  task automatic t_strobe_unmapped();
    axi_wr(IRXM_OFS_MASK_SET, 32'hffff_ffff, 4'h2, IRXM_RESP_OKAY);
    check("mask byte set", chan_mask, 32'h8000_ff00);
    axi_wr(8'h78, 32'hffff_ffff, 4'hf, IRXM_RESP_SLVERR);
    check("mask untouched", chan_mask, 32'h8000_ff00);
    axi_rd(8'h78, 32'h0, IRXM_RESP_SLVERR);
    axi_rd(IRXM_OFS_MASK_SET, 32'h8000_ff00, IRXM_RESP_OKAY);
  endtask

  task automatic t_packets();
    send_pkt(6'h3f, 1'b1, 3'b111);
    send_pkt(6'h20, 1'b1, 3'b101);
    send_pkt(6'h28, 1'b1, 3'b111);
    send_pkt(6'h28, 1'b0, 3'b101);
    send_pkt(6'h3f, 1'b0, 3'b101);
    send_pkt(6'h05, 1'b1, 3'b100);
  endtask

  task automatic t_clear_lane();
    axi_wr(IRXM_OFS_MASK_CLR, 32'hffff_ffff, 4'h2, IRXM_RESP_OKAY);
    check("mask lane cleared", chan_mask, 32'h8000_0000);
    send_pkt(6'h28, 1'b1, 3'b101);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    gate = 1'b0;
    pkt = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_set_clear();
    t_strobe_unmapped();
    t_packets();
    t_clear_lane();
    close_out();
  end

  // Whole run needs under two hundred cycles; this limit of 5000 cycles is far beyond it
  initial
  begin
    #(25 * 5000);
    failures++;
    close_out();
  end

endmodule
`default_nettype wire
